// ---- host_port_pkg.sv ----
// Package for the parallel host CPU port: widths, polarity defaults, register map.
// Assumes one clock domain (ref_clk, 20 MHz) shared by both ends.
package host_port_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int LOC_N = 512;
    // ------------------------------------------------------------
    // Polarity control bits (1 = active high)
    // ------------------------------------------------------------
    localparam int POL_CS = 0;
    localparam int POL_RW = 1;
    localparam int POL_WIDE = 2;
    localparam int POL_STRB = 3;
    localparam int POL_ACK = 4;
    localparam int POL_W = 5;
    // All but read/write active low after reset; read/write high means read.
    localparam logic [4:0] POL_RESET = 5'h02;
    // ------------------------------------------------------------
    // Device internal locations with a side effect
    // ------------------------------------------------------------
    localparam logic [8:0] LOC_POLARITY = 9'h000;
    localparam logic [8:0] LOC_IRQ_SET = 9'h001;
    // ------------------------------------------------------------
    // Controller register map (Avalon-MM byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_IRQ_STAT = 5'h14;
    localparam logic [4:0] REG_IRQ_CLR = 5'h18;
    localparam logic [4:0] REG_IRQ_EN = 5'h1c;
    // CTRL: bit0 go (self clearing), bit1 read, bit2 wide, bits 8..12 polarity.
    localparam int CTRL_GO = 0;
    localparam int CTRL_RD = 1;
    localparam int CTRL_WIDE = 2;
    localparam int CTRL_POL = 8;
    // Interrupt status bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DEV = 1;
    localparam int IRQ_W = 2;
endpackage : host_port_pkg

// ---- host_cpu_port_if.sv ----
// Interface joining the host controller and the device's host CPU port.
// The bench resolves the shared data bus from the two enables.
`timescale 1ns/10ps
interface host_cpu_port_if;
    logic host_chip_sel;
    logic host_rd_wr_sel;
    logic host_wide_xfer_sel;
    logic host_data_strobe;
    logic [8:0] host_word_addr;
    logic [15:0] host_data_bus_h2d;
    logic host_data_bus_h_oe;
    logic [15:0] host_data_bus_d2h;
    logic host_data_bus_d_oe;
    logic [15:0] host_data_bus_in;
    logic host_access_ack;
    logic host_irq_n;
    modport device (
        input host_chip_sel, host_rd_wr_sel, host_wide_xfer_sel, host_data_strobe,
        input host_word_addr, host_data_bus_in,
        output host_data_bus_d2h, host_data_bus_d_oe, host_access_ack, host_irq_n
    );
    modport host (
        output host_chip_sel, host_rd_wr_sel, host_wide_xfer_sel, host_data_strobe,
        output host_word_addr, host_data_bus_h2d, host_data_bus_h_oe,
        input host_data_bus_in, host_access_ack, host_irq_n
    );
endinterface : host_cpu_port_if

// ---- host_cpu_port.sv ----
// Device end of the parallel host CPU port: a 512-word location store.
// Assumes pins are synchronous to ref_clk and the bench resolves the data bus.
// Notes on behaviour
// R1 - Interrupt output is active low
// R2 - Host gives word addresses only
// R3 - Acknowledge when write stored or read valid
// R4 - Acknowledge polarity programmable, low after reset
// R5 - Access only while chip select active
// R6 - 16-bit data bus, device drives reads
// R7 - Read/write pin, high reads by default
// R8 - Size pin active level selects 32-bit
// R9 - 32-bit: second access auto-increments address
// R10 - Write data captured on strobe
// R11 - Read strobe asks device for data
// R12 - Strobe polarity programmable, low after reset
// R13 - No time stamping or encryption here
// R14 - Ack drops after strobe or select ends
// R15 - 32-bit pair starts at lower word
`timescale 1ns/10ps
module host_cpu_port (
    input wire logic ref_clk,
    input wire logic sys_rst,
    host_cpu_port_if.device port,
    input wire logic irq_req,
    output logic irq_pending
);
    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, ACK, WAIT_REL} dev_state_t;
    dev_state_t state_r;
    logic [15:0] mem_r [host_port_pkg::LOC_N];
    logic [4:0] pol_r;
    logic second_r;
    logic [15:0] rdata_r;
    logic d_oe_r;
    logic ack_r;
    logic irq_r;

    // ------------------------------------------------------------
    // Pin decode through the programmed polarities
    // ------------------------------------------------------------
    wire cs_act = ~(port.host_chip_sel ^ pol_r[host_port_pkg::POL_CS]); // R5
    wire rd_act = ~(port.host_rd_wr_sel ^ pol_r[host_port_pkg::POL_RW]); // R7
    wire wide_act = ~(port.host_wide_xfer_sel ^ pol_r[host_port_pkg::POL_WIDE]); // R8
    wire strb_act = ~(port.host_data_strobe ^ pol_r[host_port_pkg::POL_STRB]); // R12
    wire access = cs_act & strb_act;
    // Second access of a wide pair goes to the next word.
    wire [8:0] eff_addr = port.host_word_addr + {8'h00, wide_act & second_r}; // R9 R15
    wire wr_go = (state_r == IDLE) & access & ~rd_act;
    wire rd_go = (state_r == IDLE) & access & rd_act;
    // Ack pin level: active level of ack while asserted.
    wire ack_pin = ack_r ~^ pol_r[host_port_pkg::POL_ACK]; // R4

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= IDLE;
            ack_r <= 1'b0;
            d_oe_r <= 1'b0;
            second_r <= 1'b0;
        end else begin
            case (state_r)
                IDLE: begin
                    if (access) begin
                        state_r <= ACK;
                        ack_r <= 1'b1; // R3
                        d_oe_r <= rd_act; // R6 R11
                    end
                end
                ACK: begin
                    if (!access) begin // R14
                        ack_r <= 1'b0;
                        d_oe_r <= 1'b0;
                        state_r <= IDLE;
                        second_r <= wide_act ? ~second_r : 1'b0;
                    end
                end
                default: state_r <= IDLE;
            endcase
            if (!cs_act && state_r == IDLE) begin
                second_r <= 1'b0;
            end
        end
    end

    // Data path; host data moves straight to and from the store, except reads of LOC_POLARITY, which return pol_r.  // R13
    always_ff @(posedge ref_clk) begin
        if (wr_go) begin
            mem_r[eff_addr] <= port.host_data_bus_in; // R10
        end
        if (rd_go) begin
            rdata_r <= (eff_addr == host_port_pkg::LOC_POLARITY)
                ? {11'h000, pol_r} : mem_r[eff_addr];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pol_r <= host_port_pkg::POL_RESET;
            irq_r <= 1'b0;
        end else begin
            if (wr_go && eff_addr == host_port_pkg::LOC_POLARITY) begin
                pol_r <= port.host_data_bus_in[4:0];
            end
            // A new request wins over a host clear in the same cycle.
            if (irq_req) begin
                irq_r <= 1'b1;
            end else if (wr_go && eff_addr == host_port_pkg::LOC_IRQ_SET) begin
                irq_r <= port.host_data_bus_in[0];
            end
        end
    end

    assign port.host_access_ack = ack_pin;
    assign port.host_data_bus_d2h = rdata_r;
    assign port.host_data_bus_d_oe = d_oe_r;
    assign port.host_irq_n = ~irq_r; // R1
    assign irq_pending = irq_r;
endmodule : host_cpu_port

// ---- host_cpu_ctrl.sv ----
// Host end: Avalon-MM slave registers drive one access, or one wide pair of accesses, on the host CPU port.
// Assumes the device end runs on the same ref_clk.
`timescale 1ns/10ps
module host_cpu_ctrl (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    host_cpu_port_if.host port
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {H_IDLE, H_STRB, H_REL} host_state_t;
    host_state_t state_r;
    logic rd_r, wide_r, second_r, busy_r;
    logic [4:0] pol_r;
    logic [8:0] addr_r;
    logic [31:0] wdata_r, rdata_r, readdata_r;
    logic [1:0] ist_r, ien_r;
    logic irq_r, wait_r;
    logic cs_r, strb_r, oe_r;
    logic dev_irq_q;

    wire ack_act = ~(port.host_access_ack ^ pol_r[host_port_pkg::POL_ACK]);
    wire acc = avs_read | avs_write;
    wire wr_ctrl = avs_write & ~wait_r & (avs_address == host_port_pkg::REG_CTRL);
    wire go = wr_ctrl & avs_writedata[host_port_pkg::CTRL_GO] & ~busy_r;
    wire done = (state_r == H_REL) & ~ack_act & ~(wide_r & ~second_r);
    wire dev_irq = ~port.host_irq_n;
    wire [31:0] rd_mux =
        (avs_address == host_port_pkg::REG_CTRL) ? {19'h0, pol_r, 5'h0, wide_r, rd_r, 1'b0} :
        (avs_address == host_port_pkg::REG_ADDR) ? {23'h0, addr_r} :
        (avs_address == host_port_pkg::REG_WDATA) ? wdata_r :
        (avs_address == host_port_pkg::REG_RDATA) ? rdata_r :
        (avs_address == host_port_pkg::REG_STATUS) ? {31'h0, busy_r} :
        (avs_address == host_port_pkg::REG_IRQ_STAT) ? {30'h0, ist_r} :
        (avs_address == host_port_pkg::REG_IRQ_EN) ? {30'h0, ien_r} : 32'h0;

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            readdata_r <= 32'h0;
            pol_r <= host_port_pkg::POL_RESET;
            rd_r <= 1'b0;
            wide_r <= 1'b0;
            addr_r <= 9'h000;
            wdata_r <= 32'h0;
            ien_r <= 2'h0;
        end else begin
            wait_r <= ~(acc & wait_r);
            if (acc & wait_r) begin
                readdata_r <= rd_mux;
            end
            if (wr_ctrl && !busy_r) begin
                rd_r <= avs_writedata[host_port_pkg::CTRL_RD];
                wide_r <= avs_writedata[host_port_pkg::CTRL_WIDE];
                pol_r <= avs_writedata[host_port_pkg::CTRL_POL +: 5];
            end
            if (avs_write && !wait_r && !busy_r) begin
                if (avs_address == host_port_pkg::REG_ADDR) addr_r <= avs_writedata[8:0];
                if (avs_address == host_port_pkg::REG_WDATA) wdata_r <= avs_writedata;
            end
            if (avs_write && !wait_r && avs_address == host_port_pkg::REG_IRQ_EN) begin
                ien_r <= avs_writedata[1:0];
            end
        end
    end

    // Sticky events; a set in the clear cycle survives.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ist_r <= 2'h0;
            irq_r <= 1'b0;
            dev_irq_q <= 1'b0;
        end else begin
            dev_irq_q <= dev_irq;
            ist_r <= (ist_r & ~((avs_write && !wait_r &&
                      avs_address == host_port_pkg::REG_IRQ_CLR) ? avs_writedata[1:0] : 2'h0))
                     | {dev_irq & ~dev_irq_q, done};
            irq_r <= |(ist_r & ien_r);
        end
    end

    // ------------------------------------------------------------
    // Pin sequencer: select+strobe, wait ack, release, wait ack drop
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= H_IDLE;
            busy_r <= 1'b0;
            second_r <= 1'b0;
            cs_r <= 1'b0;
            strb_r <= 1'b0;
            oe_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (go) begin
                        busy_r <= 1'b1;
                        second_r <= 1'b0;
                        cs_r <= 1'b1;
                        strb_r <= 1'b1;
                        oe_r <= ~avs_writedata[host_port_pkg::CTRL_RD]; // R10
                        state_r <= H_STRB;
                    end
                end
                H_STRB: begin
                    if (ack_act) begin
                        if (rd_r && second_r) rdata_r[31:16] <= port.host_data_bus_in;
                        if (rd_r && !second_r) rdata_r[15:0] <= port.host_data_bus_in;
                        strb_r <= 1'b0;
                        cs_r <= wide_r & ~second_r;
                        oe_r <= 1'b0;
                        state_r <= H_REL;
                    end
                end
                H_REL: begin
                    if (!ack_act) begin // R14
                        if (wide_r && !second_r) begin
                            second_r <= 1'b1;
                            strb_r <= 1'b1;
                            oe_r <= ~rd_r;
                            state_r <= H_STRB;
                        end else begin
                            busy_r <= 1'b0;
                            cs_r <= 1'b0;
                            state_r <= H_IDLE;
                        end
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    // Pin levels through the programmed polarities; addr stays at the low word.
    assign port.host_chip_sel = cs_r ~^ pol_r[host_port_pkg::POL_CS];
    assign port.host_data_strobe = strb_r ~^ pol_r[host_port_pkg::POL_STRB];
    assign port.host_rd_wr_sel = rd_r ~^ pol_r[host_port_pkg::POL_RW];
    assign port.host_wide_xfer_sel = wide_r ~^ pol_r[host_port_pkg::POL_WIDE];
    assign port.host_word_addr = addr_r; // R2
    assign port.host_data_bus_h2d = second_r ? wdata_r[31:16] : wdata_r[15:0]; // R15
    assign port.host_data_bus_h_oe = oe_r;
    assign avs_readdata = readdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;
endmodule : host_cpu_ctrl

// ---- host_port_checker_properties.sv ----
// Pin-level checker for the host CPU port, written for the reset polarity of every pin.
// Instantiated by the bench beside the interface; sees only the interface's signals.
`timescale 1ns/10ps
module host_port_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic host_chip_sel,
    input wire logic host_rd_wr_sel,
    input wire logic host_wide_xfer_sel,
    input wire logic host_data_strobe,
    input wire logic host_data_bus_h_oe,
    input wire logic host_data_bus_d_oe,
    input wire logic host_access_ack,
    input wire logic host_irq_n
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    AST_RESET_IDLE: assert property ($past(sys_rst) |-> host_access_ack && host_irq_n)
        else $error("ack or interrupt active right after reset");
    AST_ACK_ANSWER: assert property (($fell(host_data_strobe) && !host_chip_sel
        && host_access_ack) |=> !host_access_ack)
        else $error("ack missing one cycle after strobe");
    AST_ACK_CAUSE: assert property ($fell(host_access_ack)
        |-> $past(!host_chip_sel && !host_data_strobe))
        else $error("ack without select and strobe");
    AST_ACK_RELEASE: assert property ((!host_access_ack && (host_data_strobe || host_chip_sel))
        |=> host_access_ack)
        else $error("ack held after strobe or select ended");
    AST_ACK_HOLD: assert property ((!host_access_ack && !host_data_strobe && !host_chip_sel)
        |=> !host_access_ack)
        else $error("ack dropped while access still held");
    AST_READ_DRIVE: assert property ((!host_access_ack && host_rd_wr_sel)
        |-> host_data_bus_d_oe)
        else $error("read acknowledged without data driven");
    // The device only sees the release one edge late, so it may still drive while ack stands.
    AST_DEV_DRIVE: assert property (host_data_bus_d_oe
        |-> host_rd_wr_sel && (!host_chip_sel || !host_access_ack))
        else $error("device drives bus outside a read");
    AST_WRITE_DATA: assert property ((!host_data_strobe && !host_chip_sel && !host_rd_wr_sel)
        |-> host_data_bus_h_oe && !host_data_bus_d_oe)
        else $error("write strobe without host data");
    AST_HOST_WAITS: assert property ($fell(host_data_strobe) |-> host_access_ack)
        else $error("new strobe before ack release");
    cover property (!host_wide_xfer_sel && $fell(host_access_ack));
    cover property (host_rd_wr_sel && $fell(host_access_ack));
    cover property ($fell(host_irq_n));
endmodule : host_port_checker

// ---- test_host_microcontroller_port.sv ----
// Self-checking bench: controller and device joined by the interface, driven over Avalon-MM.
// Assumes default pin polarity; the bench resolves the shared data bus from both enables.
`timescale 1ns/10ps
module test_host_microcontroller_port;
    logic ref_clk;
    logic sys_rst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic irq_req;
    logic irq_pending;
    logic [15:0] float_pat;
    logic [31:0] rd;
    int bad_count;
    int tests_run;
    host_cpu_port_if bus();
    // An undriven bus shows a moving pattern so stale data can never look valid.
    assign bus.host_data_bus_in = bus.host_data_bus_h_oe ? bus.host_data_bus_h2d :
        bus.host_data_bus_d_oe ? bus.host_data_bus_d2h : float_pat;
    always @(posedge ref_clk) float_pat <= float_pat + 16'h3b1d;
    host_cpu_port host_cpu_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .port(bus),
        .irq_req(irq_req), .irq_pending(irq_pending));
    host_cpu_ctrl host_cpu_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .port(bus));
    host_port_checker host_port_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .host_chip_sel(bus.host_chip_sel), .host_rd_wr_sel(bus.host_rd_wr_sel),
        .host_wide_xfer_sel(bus.host_wide_xfer_sel), .host_data_strobe(bus.host_data_strobe),
        .host_data_bus_h_oe(bus.host_data_bus_h_oe), .host_data_bus_d_oe(bus.host_data_bus_d_oe),
        .host_access_ack(bus.host_access_ack), .host_irq_n(bus.host_irq_n));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask : check
    task automatic timed_out();
        $display("ERROR wait bound expected 0 seen 1");
        bad_count++;
        print_verdict();
    endtask : timed_out
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) timed_out();
    endtask : av
    // Every control write repeats the reset polarity so the pins keep their levels.
    task automatic access(input logic [8:0] a, input logic rd_bit, input logic wide_bit);
        int n;
        n = 0;
        av(1'b1, host_port_pkg::REG_ADDR, {23'h000000, a});
        av(1'b1, host_port_pkg::REG_CTRL,
            {19'h00000, host_port_pkg::POL_RESET, 5'h00, wide_bit, rd_bit, 1'b1});
        rd = 32'h00000001;
        while (rd[0] !== 1'b0 && n < 50) begin
            av(1'b0, host_port_pkg::REG_STATUS, 32'h00000000);
            n++;
        end
        if (n >= 50) timed_out();
    endtask : access
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check("ack idle", {31'h0, bus.host_access_ack}, 32'h00000001);
        check("select idle", {31'h0, bus.host_chip_sel}, 32'h00000001);
        check("irq pin idle", {31'h0, bus.host_irq_n}, 32'h00000001);
        av(1'b0, host_port_pkg::REG_CTRL, 32'h00000000);
        check("ctrl reset", rd, {19'h00000, host_port_pkg::POL_RESET, 8'h00});
        av(1'b0, 5'h03, 32'hffffffff);
        check("unmapped read", rd, 32'h00000000);
        access(host_port_pkg::LOC_POLARITY, 1'b1, 1'b0);
        av(1'b0, host_port_pkg::REG_RDATA, 32'h00000000);
        check("device polarity", {16'h0000, rd[15:0]},
            {27'h0000000, host_port_pkg::POL_RESET});
        $display("test reset done");
    endtask : test_reset
    task automatic test_single();
        av(1'b1, host_port_pkg::REG_WDATA, 32'h00000f0f);
        access(9'h154, 1'b0, 1'b0);
        av(1'b1, host_port_pkg::REG_WDATA, 32'h0000a5c3);
        access(9'h155, 1'b0, 1'b0);
        av(1'b0, host_port_pkg::REG_IRQ_STAT, 32'h00000000);
        check("done flag", rd & 32'h00000003, 32'h00000001);
        av(1'b1, host_port_pkg::REG_IRQ_CLR, 32'h00000001);
        access(9'h155, 1'b1, 1'b0);
        av(1'b0, host_port_pkg::REG_RDATA, 32'h00000000);
        check("single read", {16'h0000, rd[15:0]}, 32'h0000a5c3);
        av(1'b0, host_port_pkg::REG_IRQ_STAT, 32'h00000000);
        check("done cleared then set", rd & 32'h00000003, 32'h00000001);
        $display("test single done");
    endtask : test_single
    task automatic test_wide();
        av(1'b1, host_port_pkg::REG_WDATA, 32'h89ab4c5d);
        access(9'h1fe, 1'b0, 1'b1);
        access(9'h1ff, 1'b1, 1'b0);
        av(1'b0, host_port_pkg::REG_RDATA, 32'h00000000);
        check("upper word", {16'h0000, rd[15:0]}, 32'h000089ab);
        access(9'h1fe, 1'b1, 1'b0);
        av(1'b0, host_port_pkg::REG_RDATA, 32'h00000000);
        check("lower word", {16'h0000, rd[15:0]}, 32'h00004c5d);
        access(9'h1fe, 1'b1, 1'b1);
        av(1'b0, host_port_pkg::REG_RDATA, 32'h00000000);
        check("wide read", rd, 32'h89ab4c5d);
        $display("test wide done");
    endtask : test_wide
    task automatic test_irq();
        int n;
        n = 0;
        av(1'b1, host_port_pkg::REG_IRQ_CLR, 32'h00000003);
        av(1'b1, host_port_pkg::REG_IRQ_EN, 32'h00000002);
        irq_req <= 1'b1;
        @(posedge ref_clk);
        irq_req <= 1'b0;
        while (bus.host_irq_n !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20) timed_out();
        check("device flag", {31'h0, irq_pending}, 32'h00000001);
        av(1'b0, host_port_pkg::REG_IRQ_STAT, 32'h00000000);
        check("device irq status", rd & 32'h00000002, 32'h00000002);
        check("irq enabled", {31'h0, irq}, 32'h00000001);
        av(1'b1, host_port_pkg::REG_IRQ_EN, 32'h00000000);
        repeat (2) @(posedge ref_clk);
        #1 check("irq masked", {31'h0, irq}, 32'h00000000);
        av(1'b1, host_port_pkg::REG_WDATA, 32'h00000000);
        access(host_port_pkg::LOC_IRQ_SET, 1'b0, 1'b0);
        check("irq pin released", {31'h0, bus.host_irq_n}, 32'h00000001);
        av(1'b1, host_port_pkg::REG_IRQ_CLR, 32'h00000002);
        av(1'b0, host_port_pkg::REG_IRQ_STAT, 32'h00000000);
        check("status cleared", rd & 32'h00000002, 32'h00000000);
        $display("test irq done");
    endtask : test_irq
    initial begin
        bad_count = 0;
        tests_run = 0;
        float_pat = 16'h0000;
        sys_rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        irq_req = 1'b0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1 test_reset();
        test_single();
        test_wide();
        test_irq();
        print_verdict();
    end
endmodule : test_host_microcontroller_port
